// File: core/ccdseq_pkg.sv
// Constants and types for the CCD readout sequencer
package ccdseq_pkg;
	localparam int CLK_NS = 25;
	// Pixel period, at least 200 ns; 250 ns gives an even split of halves
	localparam int PIX_NS = 250;
	localparam int PIX_CYC = (PIX_NS + CLK_NS - 1) / CLK_NS;
	localparam int PIX_HALF = PIX_CYC / 2;
	localparam int RST_NS = 50;
	localparam int RST_CYC = (RST_NS + CLK_NS - 1) / CLK_NS;
	localparam int VPW_US = 4;
	localparam int VPW_CYC = (VPW_US * 1000 + CLK_NS - 1) / CLK_NS;
	localparam int HS_NS = 500;
	localparam int HS_CYC = (HS_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [3:0] PH_LAST = 4'(PIX_CYC - 1);
	localparam logic [3:0] PH_HALF = 4'(PIX_HALF);
	localparam logic [3:0] PH_RST = 4'(PIX_CYC - RST_CYC);
	localparam logic [3:0] PH_SAMPLE = 4'(PIX_CYC - RST_CYC - 1);
	localparam logic [15:0] VPW_LAST = 16'(VPW_CYC - 1);
	localparam logic [15:0] HS_LAST = 16'(HS_CYC - 1);
	localparam int IMG_COLS = 1024;
	localparam int DARK_LEFT = 4;
	localparam int DARK_RIGHT = 8;
	localparam int HREG_EXTRA = 8;
	localparam int IMG_ROWS = 1024;
	localparam int DARK_TOP = 4;
	localparam int DARK_BOTTOM = 4;
	localparam logic [10:0] HPIX_LAST =
		11'(IMG_COLS + DARK_LEFT + DARK_RIGHT + HREG_EXTRA - 1);
	localparam logic [10:0] LINES_TOTAL =
		11'(IMG_ROWS + DARK_TOP + DARK_BOTTOM);
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_EXPOSE = 3'b001,
		ST_VA = 3'b010,
		ST_VSWAP = 3'b011,
		ST_VBACK = 3'b100,
		ST_HSETUP = 3'b101,
		ST_HREAD = 3'b110,
		ST_DONE = 3'b111
	} ccdseq_state_e;
	typedef enum logic {
		SEL_WIDE = 1'b0,
		SEL_SENS = 1'b1
	} ccdseq_sel_e;
endpackage

// File: core/ccdseq_pixdiv.sv
// Free-running pixel phase divider
`timescale 1ns/1ps
`default_nettype none
module ccdseq_pixdiv (
	input wire logic clk_in,
	input wire logic rst_in,
	output logic [3:0] phase_out,
	output logic wrap_out
);
	import ccdseq_pkg::*;
	logic [3:0] ph_r;
	logic [3:0] ph_nxt;
	always_comb begin
		ph_nxt = (ph_r == PH_LAST) ? 4'h0 : ph_r + 4'h1;
	end
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			ph_r <= 4'h0;
		end else begin
			ph_r <= ph_nxt;
		end
	end
	assign phase_out = ph_r;
	assign wrap_out = (ph_r == PH_LAST);
endmodule
`default_nettype wire

// File: core/ccdseq_ctrl.sv
// Timing generator that clocks a full-frame two-phase CCD through one frame
// Functional notes
// - Light is blocked (shutter closed) whenever charge is being moved.
// - Both vertical phases stay low for the whole user-chosen exposure.
// - A line moves: A high, both phases swap, swap again, then A low.
// - The horizontal phases are complementary while a line shifts out.
// - Line transfer and line readout repeat until the whole frame is read.
// - Wide output: split gate B held low, split gate A copies horiz B.
// - Sensitive output: split gate A held low, split gate B copies horiz B.
// - The node reset pulses after each pixel has been sampled.
// - The node reset runs continuously, during and between readouts.
// - The static split gate sits at the low level of horizontal B.
// - Each horizontal pixel period is at least 200 ns.
// - Each vertical phase pulse lasts at least 4 us.
`timescale 1ns/1ps
`default_nettype none
module ccdseq_ctrl (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic expose_in,
	input wire ccdseq_pkg::ccdseq_sel_e out_sel_in,
	output logic vert_phase_a_out,
	output logic vert_phase_b_out,
	output logic horiz_phase_a_out,
	output logic horiz_phase_b_out,
	output logic split_gate_a_out,
	output logic split_gate_b_out,
	output logic node_reset_out,
	output logic shutter_open_out,
	output logic sample_out,
	output logic busy_out,
	output logic frame_done_out
);
	import ccdseq_pkg::*;

	logic [3:0] phase;
	logic wrap;
	ccdseq_pixdiv u_div (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.phase_out(phase),
		.wrap_out(wrap)
	);

	ccdseq_state_e state_r, state_nxt;
	ccdseq_sel_e sel_r, sel_nxt;
	logic [15:0] cnt_r, cnt_nxt;
	logic [10:0] line_r, line_nxt;
	logic [10:0] pix_r, pix_nxt;

	always_comb begin
		state_nxt = state_r;
		sel_nxt = sel_r;
		cnt_nxt = cnt_r + 16'h0001;
		line_nxt = line_r;
		pix_nxt = pix_r;
		case (state_r)
			ST_IDLE: begin
				cnt_nxt = 16'h0000;
				if (expose_in) begin
					sel_nxt = out_sel_in;
					line_nxt = 11'h000;
					state_nxt = ST_EXPOSE;
				end
			end
			ST_EXPOSE: begin
				// Exposure length is whatever the user holds expose_in for
				cnt_nxt = 16'h0000;
				if (!expose_in) begin
					state_nxt = ST_VA;
				end
			end
			ST_VA: begin
				if (cnt_r == VPW_LAST) begin
					cnt_nxt = 16'h0000;
					state_nxt = ST_VSWAP;
				end
			end
			ST_VSWAP: begin
				if (cnt_r == VPW_LAST) begin
					cnt_nxt = 16'h0000;
					state_nxt = ST_VBACK;
				end
			end
			ST_VBACK: begin
				if (cnt_r == VPW_LAST) begin
					cnt_nxt = 16'h0000;
					state_nxt = ST_HSETUP;
				end
			end
			ST_HSETUP: begin
				// Start shifting only on a pixel boundary after setup
				if (cnt_r >= HS_LAST) begin
					cnt_nxt = HS_LAST;
					if (wrap) begin
						pix_nxt = 11'h000;
						state_nxt = ST_HREAD;
					end
				end
			end
			ST_HREAD: begin
				cnt_nxt = 16'h0000;
				if (wrap) begin
					if (pix_r == HPIX_LAST) begin
						line_nxt = line_r + 11'h001;
						if (line_r == LINES_TOTAL - 11'h001) begin
							state_nxt = ST_DONE;
						end else begin
							state_nxt = ST_VA;
						end
					end else begin
						pix_nxt = pix_r + 11'h001;
					end
				end
			end
			ST_DONE: begin
				cnt_nxt = 16'h0000;
				state_nxt = ST_IDLE;
			end
			default: begin
				cnt_nxt = 16'h0000;
				state_nxt = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			state_r <= ST_IDLE;
			sel_r <= SEL_WIDE;
			cnt_r <= 16'h0000;
			line_r <= 11'h000;
			pix_r <= 11'h000;
		end else begin
			state_r <= state_nxt;
			sel_r <= sel_nxt;
			cnt_r <= cnt_nxt;
			line_r <= line_nxt;
			pix_r <= pix_nxt;
		end
	end

	// Pin levels; all registered so the drivers see glitch-free edges
	logic reading;
	logic vpa_nxt, vpb_nxt, ha_nxt, hb_nxt, sga_nxt, sgb_nxt;
	logic rst_nxt, shut_nxt, smp_nxt, busy_nxt, done_nxt;
	logic vpa_r, vpb_r, ha_r, hb_r, sga_r, sgb_r;
	logic rst_r, shut_r, smp_r, busy_r, done_r;

	always_comb begin
		reading = (state_r == ST_HREAD);
		vpa_nxt = (state_r == ST_VA) || (state_r == ST_VBACK);
		vpb_nxt = (state_r == ST_VSWAP);
		hb_nxt = reading && (phase < PH_HALF);
		ha_nxt = reading ? !hb_nxt : 1'b1;
		// The idle split gate is simply held at the low level
		sga_nxt = (sel_r == SEL_WIDE) ? hb_nxt : 1'b0;
		sgb_nxt = (sel_r == SEL_SENS) ? hb_nxt : 1'b0;
		smp_nxt = reading && (phase == PH_SAMPLE);
		// Reset never gated, so the node stays clean between frames too
		rst_nxt = (phase >= PH_RST);
		shut_nxt = (state_r == ST_EXPOSE);
		busy_nxt = (state_r != ST_IDLE);
		done_nxt = (state_r == ST_DONE);
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			vpa_r <= 1'b0;
			vpb_r <= 1'b0;
			ha_r <= 1'b1;
			hb_r <= 1'b0;
			sga_r <= 1'b0;
			sgb_r <= 1'b0;
			rst_r <= 1'b0;
			shut_r <= 1'b0;
			smp_r <= 1'b0;
			busy_r <= 1'b0;
			done_r <= 1'b0;
		end else begin
			vpa_r <= vpa_nxt;
			vpb_r <= vpb_nxt;
			ha_r <= ha_nxt;
			hb_r <= hb_nxt;
			sga_r <= sga_nxt;
			sgb_r <= sgb_nxt;
			rst_r <= rst_nxt;
			shut_r <= shut_nxt;
			smp_r <= smp_nxt;
			busy_r <= busy_nxt;
			done_r <= done_nxt;
		end
	end

	assign vert_phase_a_out = vpa_r;
	assign vert_phase_b_out = vpb_r;
	assign horiz_phase_a_out = ha_r;
	assign horiz_phase_b_out = hb_r;
	assign split_gate_a_out = sga_r;
	assign split_gate_b_out = sgb_r;
	assign node_reset_out = rst_r;
	assign shutter_open_out = shut_r;
	assign sample_out = smp_r;
	assign busy_out = busy_r;
	assign frame_done_out = done_r;

	// Helper counters of how long each vertical phase has stayed high
	logic [15:0] vahi_r, vbhi_r, vahi_nxt, vbhi_nxt;
	always_comb begin
		vahi_nxt = vpa_r ? vahi_r + 16'h0001 : 16'h0000;
		vbhi_nxt = vpb_r ? vbhi_r + 16'h0001 : 16'h0000;
	end
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			vahi_r <= 16'h0000;
			vbhi_r <= 16'h0000;
		end else begin
			vahi_r <= vahi_nxt;
			vbhi_r <= vbhi_nxt;
		end
	end

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);

	AST_SHUT_CLOSED: assert property (
		(vpa_r || vpb_r || reading) |-> !shut_r)
		else $error("Shutter open while charge moves");
	AST_EXPOSE_LOW: assert property (
		shut_r |-> (!vpa_r && !vpb_r))
		else $error("Vertical phase high during exposure");
	AST_SWAP_ORDER: assert property (
		$rose(vpb_r) |-> ($past(vpa_r) && !vpa_r) ##1 (vpb_r [*8]))
		else $error("Vertical swap out of order");
	AST_VA_WIDTH: assert property (
		$fell(vpa_r) |-> (vahi_r >= 16'(VPW_CYC)))
		else $error("Vertical A pulse too short");
	AST_VB_WIDTH: assert property (
		$fell(vpb_r) |-> (vbhi_r >= 16'(VPW_CYC)))
		else $error("Vertical B pulse too short");
	AST_H_COMPL: assert property (
		busy_r && !vpa_r && !vpb_r && hb_r |-> !ha_r)
		else $error("Horizontal phases not complementary");
	AST_H_PIXEL: assert property (
		$rose(hb_r) |-> hb_r [*5] ##1 !hb_r [*5])
		else $error("Horizontal pixel period wrong");
	AST_GATE_WIDE: assert property (
		(sel_r == SEL_WIDE) |-> (sga_r == hb_r) && !sgb_r)
		else $error("Wide output gates wrong");
	AST_GATE_SENS: assert property (
		(sel_r == SEL_SENS) && busy_r |-> (sgb_r == hb_r) && !sga_r)
		else $error("Sensitive output gates wrong");
	AST_RESET_AFTER: assert property (
		smp_r |=> rst_r [*2] ##1 !rst_r)
		else $error("Node reset did not follow sample");
	AST_RESET_RUNS: assert property (
		$fell(rst_r) |-> ##[1:8] rst_r)
		else $error("Node reset stopped");
	AST_NO_MIX: assert property (
		$rose(vpa_r) && (line_r != 11'h000) |-> (pix_r == HPIX_LAST))
		else $error("Vertical transfer before line finished");
	AST_ALL_LINES: assert property (
		done_r |-> (line_r == LINES_TOTAL))
		else $error("Frame ended early");
	AST_SEL_FIXED: assert property (
		(state_r != ST_IDLE) && ($past(state_r) != ST_IDLE) |-> $stable(sel_r))
		else $error("Output select changed mid-frame");

	COV_FRAME: cover property (done_r);
	COV_SENS: cover property ((sel_r == SEL_SENS) && smp_r);
	COV_LINE: cover property ($fell(vpa_r) ##[1:100] $rose(hb_r));
endmodule
`default_nettype wire

// File: verif/ccdseq_sensor.sv
// Behavioural full-frame sensor that counts line loads and packet dumps
`timescale 1ns/1ps
`default_nettype none
module ccdseq_sensor
	import ccdseq_pkg::*;
(
	input wire logic rst_in,
	input wire logic vert_phase_b_in,
	input wire logic split_gate_a_in,
	input wire logic split_gate_b_in,
	output int lines_out,
	output int wide_out,
	output int sens_out
);
	// Only real pixels carry charge; the extra shifts push empty wells
	localparam int ROW = IMG_COLS + DARK_LEFT + DARK_RIGHT;
	int wl, wn, sl, sn;
	always @(posedge vert_phase_b_in or posedge rst_in) begin
		if (rst_in) begin
			lines_out = 0;
		end else begin
			lines_out++;
		end
	end
	// Each gate keeps its own tally per loaded line, so no shared writer
	always @(negedge split_gate_a_in or posedge rst_in) begin
		if (rst_in) begin
			wide_out = 0;
			wl = 0;
			wn = 0;
		end else begin
			if (wl != lines_out) begin
				wl = lines_out;
				wn = 0;
			end
			if (wl > 0 && wn < ROW) begin
				wide_out++;
				wn++;
			end
		end
	end
	always @(negedge split_gate_b_in or posedge rst_in) begin
		if (rst_in) begin
			sens_out = 0;
			sl = 0;
			sn = 0;
		end else begin
			if (sl != lines_out) begin
				sl = lines_out;
				sn = 0;
			end
			if (sl > 0 && sn < ROW) begin
				sens_out++;
				sn++;
			end
		end
	end
endmodule
`default_nettype wire

// File: verif/tb.sv
// Self-checking bench for the CCD readout sequencer
`timescale 1ns/1ps
`default_nettype none
module tb;
	import ccdseq_pkg::*;
	logic clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic expose_in = 1'b0;
	ccdseq_sel_e out_sel_in = SEL_WIDE;
	logic va, vb, ha, hb, sga, sgb, nrst, shut, smp, busy, fdone;
	int lines, wide, sens, n_errors = 0, checks = 0, cyc = 0;
	always #12.5 clk_in = ~clk_in;
	ccdseq_ctrl i_ccdseq_ctrl (.clk_in(clk_in), .rst_in(rst_in),
		.expose_in(expose_in), .out_sel_in(out_sel_in),
		.vert_phase_a_out(va), .vert_phase_b_out(vb),
		.horiz_phase_a_out(ha), .horiz_phase_b_out(hb),
		.split_gate_a_out(sga), .split_gate_b_out(sgb),
		.node_reset_out(nrst), .shutter_open_out(shut), .sample_out(smp),
		.busy_out(busy), .frame_done_out(fdone));
	ccdseq_sensor i_ccdseq_sensor (.rst_in(rst_in), .vert_phase_b_in(vb),
		.split_gate_a_in(sga), .split_gate_b_in(sgb),
		.lines_out(lines), .wide_out(wide), .sens_out(sens));
	task automatic chk_bit(string nm, logic e, logic g);
		checks++;
		if (g !== e) begin
			n_errors++;
			$display("BAD %s exp %b got %b", nm, e, g);
		end
	endtask
	task automatic chk_num(string nm, int e, int g);
		checks++;
		if (g !== e) begin
			n_errors++;
			$display("BAD %s exp %0d got %0d", nm, e, g);
		end
	endtask
	task automatic end_sim;
		$display("checks %0d errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic t_reset;
		int n = 0;
		rst_in = 1'b1;
		expose_in = 1'b0;
		repeat (8) @(negedge clk_in);
		rst_in = 1'b0;
		@(negedge clk_in);
		chk_bit("horiz_a", 1'b1, ha);
		chk_bit("vert_a", 1'b0, va);
		chk_bit("busy", 1'b0, busy);
		chk_bit("frame_done", 1'b0, fdone);
		repeat (100) begin
			@(negedge clk_in);
			n += int'(nrst === 1'b1);
		end
		chk_num("reset_pulses", 100 / PIX_CYC * RST_CYC, n);
	endtask
	task automatic t_expose(ccdseq_sel_e s);
		int bad = 0;
		out_sel_in = s;
		expose_in = 1'b1;
		repeat (3) @(negedge clk_in);
		chk_bit("shutter", 1'b1, shut);
		chk_bit("busy", 1'b1, busy);
		repeat (200) begin
			@(negedge clk_in);
			if (va !== 1'b0 || vb !== 1'b0 || shut !== 1'b1) bad++;
		end
		chk_num("expose_bad", 0, bad);
		expose_in = 1'b0;
	endtask
	// Flip makes the selection input change mid-line; the gates must not
	task automatic t_line(ccdseq_sel_e s, logic flip);
		int k = 0, st, pst = 0, seq = 0, run = 0, mr = 99999, bad = 0;
		int rb = 0, smps = 0, rises = 0, per = 0, mp = 99999, pend = 0;
		int l0 = lines, w0 = wide, s0 = sens;
		logic phb = hb;
		while (va !== 1'b1 && vb !== 1'b1 && k < 2000) begin
			@(negedge clk_in);
			k++;
		end
		while (k < 4000) begin
			st = {va, vb};
			if (st != pst) begin
				if (pst != 0 && run < mr) mr = run;
				seq = seq * 4 + st;
				run = 0;
				pst = st;
			end
			if (st == 0) break;
			run++;
			if (hb !== 1'b0 || shut !== 1'b0) bad++;
			@(negedge clk_in);
			k++;
		end
		chk_num("vert_order", 152, seq);
		chk_num("vert_width", VPW_CYC, mr);
		chk_num("lines", l0 + 1, lines);
		chk_num("vert_bad", 0, bad);
		bad = 0;
		k = 0;
		while (va !== 1'b1 && k < 12000) begin
			if (pend > 0 && nrst !== 1'b1) rb++;
			if (pend > 0) pend--;
			if (smp === 1'b1) begin
				smps++;
				pend = RST_CYC;
			end
			if (ha !== ~hb || vb !== 1'b0 || busy !== 1'b1) bad++;
			if (fdone !== 1'b0) bad++;
			if ((s == SEL_WIDE ? sga : sgb) !== hb) bad++;
			if ((s == SEL_WIDE ? sgb : sga) !== 1'b0) bad++;
			if (hb === 1'b1 && phb === 1'b0) begin
				rises++;
				if (rises > 1 && per < mp) mp = per;
				per = 0;
			end
			per++;
			phb = hb;
			if (flip && k == 5000) out_sel_in = ccdseq_sel_e'(~s);
			@(negedge clk_in);
			k++;
		end
		chk_num("samples", int'(HPIX_LAST) + 1, smps);
		chk_num("shifts", int'(HPIX_LAST) + 1, rises);
		chk_num("pix_period", PIX_CYC, mp);
		chk_num("gate_bad", 0, bad);
		chk_num("node_reset_bad", 0, rb);
		chk_num("dumps", IMG_COLS + DARK_LEFT + DARK_RIGHT,
			s == SEL_WIDE ? wide - w0 : sens - s0);
		chk_num("other_dumps", 0,
			s == SEL_WIDE ? sens - s0 : wide - w0);
	endtask
	// A full frame is far beyond the budget; three lines are covered
	always @(posedge clk_in) begin
		cyc++;
		if (cyc == 60000) begin
			n_errors++;
			end_sim;
		end
	end
	initial begin
		t_reset;
		t_expose(SEL_WIDE);
		t_line(SEL_WIDE, 1'b0);
		t_line(SEL_WIDE, 1'b0);
		t_reset;
		t_expose(SEL_SENS);
		t_line(SEL_SENS, 1'b1);
		end_sim;
	end
endmodule
`default_nettype wire
